// File: verilog/apc_pkg.sv
// Package for the converter power-down and mid-scale calibration control.
// Assumes a single 50 MHz core clock.
package apc_pkg;
    // ========================================================================
    // Clock and timing
    // ========================================================================
    localparam int CLK_PERIOD_NS      = 20;
    localparam int PD_ENTER_NS        = 200;
    localparam int WAKE_NS            = 1000;
    localparam int PD_ENTER_CYC       = (PD_ENTER_NS / CLK_PERIOD_NS) < 1 ? 1
                                        : PD_ENTER_NS / CLK_PERIOD_NS;
    localparam int WAKE_CYC           = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ========================================================================
    // Code and field layout
    // ========================================================================
    localparam int CODE_W             = 10;
    localparam logic [9:0] CODE_MAX   = 10'h3FF;
    localparam logic [9:0] CODE_MIN   = 10'h001;
    localparam logic [9:0] CODE_ZERO  = 10'h000;
    localparam logic [9:0] CODE_MID   = 10'h200;
    localparam logic [9:0] OFFSET_RST = 10'h200;
    localparam int CR0_CAL_HI         = 7;
    localparam int CR0_CAL_LO         = 6;
    localparam int CR1_PD_BIT         = 0;
    localparam logic       PD_RST     = 1'b0;

    typedef enum logic [1:0] {
        APC_CAL_NORMAL   = 2'b00,
        APC_CAL_SYSTEM   = 2'b01,
        APC_CAL_INTERNAL = 2'b10,
        APC_CAL_IDLE     = 2'b11
    } apc_cal_e;

    typedef enum logic [1:0] {
        APC_RUN      = 2'b00,
        APC_ENTERING = 2'b01,
        APC_DOWN     = 2'b10,
        APC_WAKING   = 2'b11
    } apc_pwr_e;
endpackage : apc_pkg

// File: verilog/apc_corr_if.sv
// Carries raw conversion data and the stored offset to the corrector.
// Assumes both ends run on the core clock.
`timescale 1ns/10ps
`default_nettype none
interface apc_corr_if;
    import apc_pkg::*;
    logic [CODE_W-1:0] raw;
    logic [CODE_W-1:0] offset;
    logic              bypass;
    logic              over;
    logic              under;
    logic [CODE_W-1:0] code;
    modport ctrl (output raw, output offset, output bypass, output over, output under,
                  input code);
    modport corr (input raw, input offset, input bypass, input over, input under,
                  output code);
endinterface : apc_corr_if
`default_nettype wire

// File: verilog/apc_offset_corr.sv
// Offset subtraction and clamping of a raw conversion code.
// Assumes inputs are stable within the core clock cycle.
`timescale 1ns/10ps
`default_nettype none
module apc_offset_corr
    import apc_pkg::*;
(
    apc_corr_if.corr c
);
    logic signed [CODE_W+1:0] diff;

    // ========================================================================
    // Correction
    // ========================================================================
    always_comb begin
        diff = $signed({2'b00, c.raw}) - $signed({2'b00, c.offset})
               + $signed({2'b00, CODE_MID});
        if (c.over) begin
            c.code = CODE_MAX;
        end else if (c.under) begin
            c.code = CODE_ZERO;
        end else if (c.bypass) begin
            c.code = c.raw;
        end else if (diff > $signed({2'b00, CODE_MAX})) begin
            c.code = CODE_MAX;
        end else if (diff < $signed({2'b00, CODE_MIN})) begin
            c.code = CODE_MIN;
        end else begin
            c.code = diff[CODE_W-1:0];
        end
    end
endmodule : apc_offset_corr
`default_nettype wire

// File: verilog/apc_ctrl.sv
// Power-down and mid-scale calibration control of a parallel-bus converter.
// Assumes host strobes already synchronous to the core clock; the analog
// core reports each finished conversion with a one-cycle done pulse.
//
// Function
// - Writing one to power-down bit enters power-down within 200 ns of chip select rise.
// - Writing zero wakes; conversions allowed 1 us after resume; rewriting one during wake-up goes straight to APC_RUN.
// - Field value 10 selects internal mid-scale calibration.
// - Internal calibration ties converter inputs to the reference midpoint.
// - Internal calibration: one read-strobe conversion loads the offset latch.
// - Field 01 selects system calibration; one read conversion loads offset.
// - Writing field 00 returns to normal conversion.
// - Stored offset is subtracted from all codes except during calibration.
// - Corrected codes span x..1023 or 1..1023-x depending on offset sign.
// - Calibration references code 512 for zero error there.
// - Over-range gives all ones, under-range gives all zeros.
// - Control contents and offset latch persist through power-down.
`timescale 1ns/10ps
`default_nettype none
module apc_ctrl
    import apc_pkg::*;
#(
    parameter int CW = CODE_W
) (
    // Clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_resetn,
    // Host bus
    input  wire logic          i_cs_n,
    input  wire logic          i_rd_n,
    input  wire logic          i_wr_n,
    input  wire logic          i_conversion_start_n,
    input  wire logic          i_cr_sel,
    input  wire logic [7:0]    i_data_in,
    output logic    [CW-1:0]   o_data_out,
    output logic               o_data_oe,
    // Analog core
    input  wire logic          i_conv_done,
    input  wire logic [CW-1:0] i_raw_code,
    input  wire logic          i_over_ref_high,
    input  wire logic          i_under_ref_low,
    output logic               o_conv_trigger,
    output logic               o_input_to_mid,
    output logic               o_analog_on,
    output logic               o_ready
);
    apc_corr_if corr_bus ();

    // Stored control fields and decoded calibration flag
    logic [1:0]    calibration_mode_field;
    logic          soft_powerdown_bit;
    logic          calibrating;

    // Power sequencing
    apc_pwr_e      pwr;
    logic [15:0]   cnt;
    logic          down;

    // Calibration capture
    logic          cal_armed;
    logic          cal_conv;
    logic [CW-1:0] offset;

    // Strobe edge detection
    logic          rd_q;
    logic          wr_q;
    logic          cs_q;
    logic          cs_rise;
    logic          rd_fall;
    logic          wr_rise;

    assign cs_rise     = ~cs_q & i_cs_n;
    assign rd_fall     = rd_q & ~i_rd_n & ~i_cs_n;
    assign wr_rise     = ~wr_q & i_wr_n & ~i_cs_n;
    assign calibrating = (calibration_mode_field == APC_CAL_INTERNAL)
                      || (calibration_mode_field == APC_CAL_SYSTEM);
    assign down        = (pwr == APC_DOWN);

    // ========================================================================
    // Edge history
    // ========================================================================
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_q <= 1'b1;
            wr_q <= 1'b1;
            cs_q <= 1'b1;
        end else begin
            rd_q <= i_rd_n;
            wr_q <= i_wr_n;
            cs_q <= i_cs_n;
        end
    end

    // ========================================================================
    // Control register writes (retained in power-down)
    // ========================================================================
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            calibration_mode_field <= APC_CAL_IDLE;
            soft_powerdown_bit     <= PD_RST;
        end else if (wr_rise) begin
            if (i_cr_sel) begin
                soft_powerdown_bit <= i_data_in[CR1_PD_BIT];
            end else begin
                calibration_mode_field <= i_data_in[CR0_CAL_HI:CR0_CAL_LO];
            end
        end
    end

    // ========================================================================
    // Power sequencing
    // ========================================================================
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pwr        <= APC_RUN;
            cnt        <= 16'h0000;
        end else begin
            case (pwr)
                APC_RUN: begin
                    if (soft_powerdown_bit && cs_rise) begin
                        pwr <= APC_ENTERING;
                        // The rise is seen one cycle late, so the count starts at one
                        cnt <= 16'h0001;
                    end
                end
                APC_ENTERING: begin
                    if (!soft_powerdown_bit) begin
                        pwr <= APC_RUN;
                    end else if (cnt >= 16'(PD_ENTER_CYC - 1)) begin
                        pwr <= APC_DOWN;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                APC_DOWN: begin
                    if (!soft_powerdown_bit) begin
                        pwr <= APC_WAKING;
                        cnt <= 16'h0000;
                    end
                end
                APC_WAKING: begin
                    // Rewriting the power-down bit cuts the wake-up short and goes straight to APC_RUN
                    if (soft_powerdown_bit) begin
                        pwr <= APC_RUN;
                    end else if (cnt >= 16'(WAKE_CYC - 1)) begin
                        pwr <= APC_RUN;
                    end else begin
                        cnt <= cnt + 16'h0001;
                    end
                end
                default: pwr <= APC_RUN;
            endcase
        end
    end

    // ========================================================================
    // Calibration conversion and offset latch
    // ========================================================================
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cal_armed <= 1'b0;
            cal_conv  <= 1'b0;
            offset    <= OFFSET_RST;
        end else begin
            if (i_conv_done && cal_conv) begin
                cal_conv <= 1'b0;
                offset   <= i_raw_code;
            end
            // A new capture set in the same cycle wins over the clear
            if (wr_rise && !i_cr_sel) begin
                cal_armed <= (i_data_in[CR0_CAL_HI:CR0_CAL_LO] == APC_CAL_INTERNAL)
                          || (i_data_in[CR0_CAL_HI:CR0_CAL_LO] == APC_CAL_SYSTEM);
            end else if (rd_fall && !down && cal_armed && calibrating) begin
                cal_armed <= 1'b0;
                cal_conv  <= 1'b1;
            end
        end
    end

    // ========================================================================
    // Trigger, midpoint tie and power status outputs
    // ========================================================================
    // Triggers are dropped while powered down
    assign o_conv_trigger = ~down && (rd_fall || (~i_conversion_start_n
                            & ~calibrating));
    assign o_input_to_mid = (calibration_mode_field == APC_CAL_INTERNAL);
    assign o_analog_on    = (pwr == APC_RUN) || (pwr == APC_ENTERING);
    assign o_ready        = (pwr == APC_RUN);

    // ========================================================================
    // Correction path
    // ========================================================================
    assign corr_bus.raw    = i_raw_code;
    assign corr_bus.offset = offset;
    assign corr_bus.bypass = calibrating;
    assign corr_bus.over   = i_over_ref_high;
    assign corr_bus.under  = i_under_ref_low;

    apc_offset_corr u_corr (
        .c (corr_bus.corr)
    );

    // ========================================================================
    // Output data register
    // ========================================================================
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_data_out <= '0;
            o_data_oe  <= 1'b0;
        end else begin
            if (i_conv_done && !down) begin
                o_data_out <= corr_bus.code;
            end
            o_data_oe <= ~down & ~i_cs_n & ~i_rd_n;
        end
    end
endmodule : apc_ctrl
`default_nettype wire

// File: testbench/apc_ctrl_properties.sv
// Port checker for the power-down and mid-scale calibration control.
// Assumes it is bound to every apc_ctrl instance by the statement at its foot.
`timescale 1ns/10ps
`default_nettype none
module apc_ctrl_properties
    import apc_pkg::*;
#(
    parameter int CW = CODE_W
) (
    // Clock and reset
    input wire logic          i_core_clk,
    input wire logic          i_resetn,
    // Host bus
    input wire logic          i_cs_n, i_rd_n, i_wr_n, i_conversion_start_n, i_cr_sel,
    input wire logic [7:0]    i_data_in,
    input wire logic [CW-1:0] o_data_out,
    input wire logic          o_data_oe,
    // Analog core
    input wire logic          i_conv_done, i_over_ref_high, i_under_ref_low,
    input wire logic [CW-1:0] i_raw_code,
    input wire logic          o_conv_trigger, o_input_to_mid, o_analog_on, o_ready
);
    // ========================================================================
    // Shadow of the written control bits
    // ========================================================================
    logic       wr_prev;
    logic       pd_bit;
    logic [1:0] cal_f;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_prev <= 1'b1;
            pd_bit  <= 1'b0;
            cal_f   <= 2'h3;
        end else begin
            wr_prev <= i_wr_n;
            if (i_wr_n && !wr_prev && !i_cs_n && i_cr_sel) pd_bit <= i_data_in[CR1_PD_BIT];
            if (i_wr_n && !wr_prev && !i_cs_n && !i_cr_sel) cal_f <= i_data_in[7:6];
        end
    end
    // ========================================================================
    // Properties
    // ========================================================================
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    sequence s_wake;
        (!o_ready throughout ##45 1) ##[1:10] o_ready;
    endsequence
    pd_enter_a: assert property ($rose(i_cs_n) && pd_bit |-> ##[1:10] !o_analog_on)
        else $error("power-down not entered in time");
    wake_hold_a: assert property ($fell(pd_bit) |-> s_wake)
        else $error("ready out of step after wake-up");
    down_quiet_a: assert property (!o_analog_on |-> !o_data_oe && !o_conv_trigger)
        else $error("activity while powered down");
    rd_trig_a: assert property ($fell(i_rd_n) && !i_cs_n && o_ready |-> o_conv_trigger)
        else $error("read fall gave no trigger");
    oe_read_a: assert property (!i_cs_n && !i_rd_n && o_ready |=> o_data_oe)
        else $error("data bus not driven on read");
    mid_tie_a: assert property (cal_f == 2'h2 |-> ##[0:1] o_input_to_mid)
        else $error("inputs not tied to midpoint");
    cal_bypass_a: assert property (i_conv_done && (cal_f == 2'h1 || cal_f == 2'h2)
        && !i_over_ref_high && !i_under_ref_low |=> o_data_out == $past(i_raw_code))
        else $error("calibration code was corrected");
    over_ones_a: assert property (i_conv_done && i_over_ref_high |=> o_data_out == CODE_MAX)
        else $error("over-range code wrong");
    under_zero_a: assert property (i_conv_done && i_under_ref_low && !i_over_ref_high
        |=> o_data_out == CODE_ZERO)
        else $error("under-range code wrong");
    floor_one_a: assert property (i_conv_done && cal_f[1] == cal_f[0] && !i_under_ref_low
        |=> o_data_out != CODE_ZERO)
        else $error("corrected code below one");
    data_hold_a: assert property (!i_conv_done |=> $stable(o_data_out))
        else $error("output code changed without conversion");
    cover property (!o_analog_on);
    cover property (i_conv_done && cal_f == 2'h2);
    cover property (i_conv_done && cal_f == 2'h1);
endmodule // apc_ctrl_properties
bind apc_ctrl apc_ctrl_properties #(.CW(CW)) u_apc_props (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n),
    .i_wr_n(i_wr_n), .i_conversion_start_n(i_conversion_start_n), .i_cr_sel(i_cr_sel),
    .i_data_in(i_data_in), .o_data_out(o_data_out), .o_data_oe(o_data_oe),
    .i_conv_done(i_conv_done), .i_over_ref_high(i_over_ref_high),
    .i_under_ref_low(i_under_ref_low), .i_raw_code(i_raw_code), .o_conv_trigger(o_conv_trigger),
    .o_input_to_mid(o_input_to_mid), .o_analog_on(o_analog_on), .o_ready(o_ready));
`default_nettype wire

// File: testbench/apc_analog_model.sv
// Behavioural analog core: answers each trigger taken while idle and powered with one done pulse.
// Assumes the trigger is sampled on the core clock edge.
`timescale 1ns/10ps
`default_nettype none
module apc_analog_model
    import apc_pkg::*;
(
    // Clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_resetn,
    // Control and levels
    input  wire logic       i_trigger,
    input  wire logic       i_to_mid,
    input  wire logic       i_powered,
    input  wire logic [9:0] i_level,
    input  wire logic [9:0] i_mid_level,
    input  wire logic [3:0] i_delay,
    // Result
    output logic            o_done,
    output logic [9:0]      o_code
);
    logic [3:0] busy;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy   <= 4'h0;
            o_done <= 1'b0;
            o_code <= CODE_MID;
        end else begin
            busy   <= (i_trigger && i_powered && busy == 4'h0) ? i_delay : busy - (busy != 4'h0);
            o_done <= busy == 4'h1;
            // Code is only valid with done; it keeps toggling otherwise
            o_code <= busy == 4'h1 ? (i_to_mid ? i_mid_level : i_level) : ~o_code;
        end
    end
endmodule // apc_analog_model
`default_nettype wire

// File: testbench/test_adc_powerdown_midscale_cal.sv
// Self-checking bench for the power-down and calibration control.
// Assumes the checker binds itself to the design.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_adc_powerdown_midscale_cal;
    import apc_pkg::*;
    logic       clk, rstn = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, cst_n = 1'b1;
    logic       sel = 1'b0, over = 1'b0, under = 1'b0, done, oe, trig, to_mid, on, ready;
    logic [7:0] din = 8'h00;
    logic [3:0] dly = 4'h1;
    logic [9:0] level = 10'h000, mid = 10'h000, raw, dout;
    int         n_fail = 0, num_checks = 0, k;
    apc_ctrl DUT (.i_core_clk(clk), .i_resetn(rstn), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_conversion_start_n(cst_n), .i_cr_sel(sel), .i_data_in(din), .o_data_out(dout),
        .o_data_oe(oe), .i_conv_done(done), .i_raw_code(raw), .i_over_ref_high(over),
        .i_under_ref_low(under), .o_conv_trigger(trig), .o_input_to_mid(to_mid),
        .o_analog_on(on), .o_ready(ready));
    apc_analog_model u_model (.i_core_clk(clk), .i_resetn(rstn), .i_trigger(trig),
        .i_to_mid(to_mid), .i_powered(on), .i_level(level), .i_mid_level(mid), .i_delay(dly),
        .o_done(done), .o_code(raw));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    function automatic logic [9:0] corr(input int r, input int off);
        int v;
        v = r - off + 512;
        return (v < 1) ? CODE_MIN : (v > 1023) ? CODE_MAX : 10'(v);
    endfunction
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr_reg(input logic s, input logic [7:0] d);
        @(posedge clk);
        {cs_n, wr_n, sel, din} <= {2'b00, s, d};
        @(posedge clk);
        wr_n <= 1'b1;
        @(posedge clk);
        cs_n <= 1'b1;
        #1;
    endtask
    task automatic convert(input logic [9:0] lv, input logic [9:0] e, input string nm);
        @(posedge clk);
        level <= lv;
        cs_n <= 1'b0;
        @(posedge clk);
        rd_n <= 1'b0;
        k = 0;
        do begin @(posedge clk); #1; k++; end while (done !== 1'b1 && k < 40);
        `CHK("conv done", 1'b1, done)
        @(posedge clk);
        #1;
        `CHK(nm, e, dout)
        `CHK("data enable", 1'b1, oe)
        @(posedge clk);
        {cs_n, rd_n} <= 2'b11;
    endtask
    task automatic t_range();
        convert(10'h12C, corr(300, 512), "plain code");
        over <= 1'b1;
        convert(10'h12C, CODE_MAX, "over range");
        {over, under} <= 2'b01;
        convert(10'h12C, CODE_ZERO, "under range");
        under <= 1'b0;
    endtask
    task automatic t_start();
        @(posedge clk);
        level <= 10'h190;
        cst_n <= 1'b0;
        @(posedge clk);
        cst_n <= 1'b1;
        k = 0;
        do begin @(posedge clk); #1; k++; end while (done !== 1'b1 && k < 40);
        `CHK("start done", 1'b1, done)
        @(posedge clk);
        #1;
        `CHK("start code", corr(400, 512), dout)
        @(posedge clk);
    endtask
    task automatic t_internal();
        mid <= 10'h208;
        wr_reg(1'b0, 8'h80);
        `CHK("tied to mid", 1'b1, to_mid)
        convert(10'h12C, 10'h208, "internal cal");
        wr_reg(1'b0, 8'h00);
        `CHK("tie released", 1'b0, to_mid)
        convert(10'h12C, corr(300, 520), "corrected");
        convert(10'h005, CODE_MIN, "low clamp");
        convert(10'h3FF, corr(1023, 520), "high end");
    endtask
    task automatic t_system();
        dly <= 4'h9;
        wr_reg(1'b0, 8'h40);
        convert(10'h1F4, 10'h1F4, "system cal");
        wr_reg(1'b0, 8'hC0);
        convert(10'h000, corr(0, 500), "floor");
        convert(10'h3FF, CODE_MAX, "top");
    endtask
    task automatic t_powerdown();
        wr_reg(1'b1, 8'h01);
        k = 0;
        while (on !== 1'b0 && k < 12) begin @(posedge clk); #1; k++; end
        `CHK("powered down", 1'b0, on)
        `CHK("enter time", 1'b1, k <= 10)
        @(posedge clk);
        {cst_n, rd_n} <= 2'b00;
        repeat (4) @(posedge clk);
        #1;
        `CHK("bus released", 1'b0, oe)
        `CHK("code kept", CODE_MAX, dout)
        @(posedge clk);
        {cst_n, rd_n} <= 2'b11;
        wr_reg(1'b1, 8'h00);
        k = 0;
        while (ready !== 1'b1 && k < 80) begin @(posedge clk); #1; k++; end
        `CHK("wake time", 1'b1, k >= 45 && k <= 55)
        convert(10'h12C, corr(300, 500), "offset kept");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        `CHK("analog on", 1'b1, on)
        `CHK("ready", 1'b1, ready)
        t_range();
        t_start();
        t_internal();
        t_system();
        t_powerdown();
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        finish_test();
    end
endmodule // test_adc_powerdown_midscale_cal
`default_nettype wire
